// ### core/ppr_hold_timer.sv
/*
 Hold timer: reports done once its condition has held for limit control ticks.
 Assumes tick is a one-cycle pulse and reset is already synchronised.
*/
`timescale 1ns/1ps
module ppr_hold_timer
	import ppr_pkg::*;
#(
	parameter int CNT_W = TMR_W
)(
	input wire logic ref_clk,
	input wire logic rstSyncB,
	input wire logic tick,
	input wire logic cond,
	input wire logic [CNT_W-1:0] limit,
	output logic done
);
	logic [CNT_W-1:0] cnt_r;

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			cnt_r <= '0;
		else if (!cond)
			cnt_r <= '0;
		else if (tick && cnt_r < limit)
			cnt_r <= cnt_r + 1'b1;
	end

	assign done = cond && (cnt_r >= limit);

	chk_timer_clear: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
		!cond |=> cnt_r == '0) else $error("hold timer kept count after condition fell");
endmodule

// ### core/ppr_lowpass.sv
/*
 First-order low-pass on the clamped controller output, stepped on control ticks.
 Assumes tick is a one-cycle pulse; lpTime is in 10 ms units.
*/
`timescale 1ns/1ps
module ppr_lowpass
	import ppr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstSyncB,
	input wire logic tick,
	input wire logic signed [31:0] x,
	input wire logic [9:0] lpTime,
	output logic signed [31:0] y
);
	logic signed [31:0] y_r;
	logic [15:0] div_r;
	logic [15:0] period;

	// Shift step of 1/8 per period gives a time constant close to lpTime
	assign period = 16'((32'(lpTime) * 10) >> LP_SHIFT);

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			div_r <= '0;
		else if (tick)
			div_r <= (div_r >= period) ? 16'h0000 : div_r + 16'h0001;
	end

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			y_r <= '0;
		else if (tick && lpTime == 10'h000)
			y_r <= x;
		else if (tick && div_r >= period)
			y_r <= y_r + ((x - y_r) >>> LP_SHIFT);
	end

	assign y = y_r;
endmodule

// ### core/ppr_pkg.sv
/*
 Shared constants, configuration carrier and state codes of the process regulator.
 Assumes a 200 MHz core clock and a 1 ms control tick made from it.
*/
package ppr_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CTL_TICK_US = 1000;
	localparam int TICK_CYCLES = (CTL_TICK_US * 1000000) / CLK_PERIOD_PS;
	localparam int TICKS_PER_TENTH = 100000 / CTL_TICK_US;
	localparam int TICK_W = 18;
	localparam int TMR_W = 18;
	localparam int MODE_EN_BIT = 0;
	localparam int MODE_POL_BIT = 1;
	localparam int PCT_FULL = 10000;
	localparam int RAMP_STEP = 100;
	localparam int LP_SHIFT = 3;
	localparam logic [15:0] FREQ_MAX = 16'hE9FC;
	localparam logic [11:0] DELAY_MAX = 12'h9FB;
	localparam logic [6:0] LOSS_TIME_MAX = 7'h64;
	localparam logic [6:0] LOSS_LEVEL_MAX = 7'h64;
	localparam logic [1:0] LOSS_OFF = 2'h0;
	localparam logic [1:0] LOSS_WARN = 2'h1;
	localparam logic [1:0] LOSS_FAULT = 2'h2;
	localparam logic [1:0] SLEEP_OFF = 2'h0;
	localparam logic [1:0] SLEEP_LEVEL = 2'h1;
	localparam logic [1:0] SLEEP_INPUT = 2'h2;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_FAULT = 2'b10
	} ppr_state_t;

	typedef struct packed {
		logic [3:0] mode;
		logic [9:0] fbGain;
		logic [9:0] kp;
		logic [9:0] ki;
		logic [9:0] kd;
		logic [9:0] integClamp;
		logic [13:0] outClamp;
		logic [9:0] lpTime;
		logic signed [7:0] bias;
		logic [7:0] outGain;
		logic reverseAllow;
		logic [7:0] rampTime;
		logic [1:0] lossSel;
		logic [6:0] lossLevel;
		logic [6:0] lossTime;
		logic [1:0] sleepSel;
		logic sleepComp;
		logic [15:0] sleepFreq;
		logic [11:0] sleepDelay;
		logic [15:0] wakeFreq;
		logic [11:0] wakeDelay;
	} ppr_cfg_t;
endpackage

// ### core/ppr_regulator.sv
/*
 Closed-loop process regulator: error, P/I/D paths, clamps, low-pass, bias and gain,
 reversal permission, target ramp, feedback loss supervision, sleep and wake-up.
 Assumes target and feedback in 0.01 % units, frequencies in 0.01 Hz, inputs synchronous.
*/
`timescale 1ns/1ps
module ppr_regulator
	import ppr_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYCLES
)(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire ppr_cfg_t cfg,
	input wire logic [15:0] target,
	input wire logic [15:0] fbIn,
	input wire logic [15:0] freqRef,
	input wire logic [15:0] maxFreq,
	input wire logic [15:0] minFreq,
	input wire logic rampBypass,
	input wire logic sleepInput,
	output logic [15:0] outFreq,
	output logic dirRev,
	output logic driveRun,
	output logic sleeping,
	output logic lossMsg,
	output logic faultRelay,
	output logic conflictAlarm,
	output logic signed [31:0] pidOut
);
	logic rstMeta_r;
	logic rstSyncB;
	logic [TICK_W-1:0] tickCnt_r;
	logic tick;
	logic loopEn;
	ppr_state_t state_r;
	logic signed [31:0] tgtRamp_r;
	logic [7:0] rampCnt_r;
	logic signed [31:0] integ_r;
	logic signed [31:0] errPrev_r;
	logic signed [31:0] sumClp_r;
	logic signed [31:0] lpOut;
	logic [15:0] outFreq_r;
	logic dirRev_r;
	logic conflict_r;
	logic signed [31:0] fbScaled;
	logic signed [31:0] err;
	logic signed [31:0] pTerm;
	logic signed [31:0] dTerm;
	logic signed [31:0] integ_nxt;
	logic signed [31:0] iLim;
	logic signed [31:0] oLim;
	logic signed [31:0] sum;
	logic signed [31:0] sumClp_nxt;
	logic signed [31:0] comp;
	logic signed [31:0] freqCmd;
	logic [15:0] cmdMag;
	logic cmdNeg;
	logic [15:0] sleepF;
	logic [15:0] wakeF;
	logic [TMR_W-1:0] lossLim;
	logic [TMR_W-1:0] sleepLim;
	logic [TMR_W-1:0] wakeLim;
	logic lossCond;
	logic lossDone;
	logic sleepCond;
	logic sleepDone;
	logic wakeCond;
	logic wakeDone;
	logic lossFaultHit;
	logic sleepEnter;
	logic wakeExit;

	// Reset is released through two flops so every flop leaves reset on the same edge
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_r <= 1'b0;
			rstSyncB <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSyncB <= rstMeta_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			tickCnt_r <= '0;
		else if (tickCnt_r == TICK_W'(TICK_COUNT - 1))
			tickCnt_r <= '0;
		else
			tickCnt_r <= tickCnt_r + 1'b1;
	end

	assign tick = (tickCnt_r == TICK_W'(TICK_COUNT - 1));
	assign loopEn = cfg.mode[MODE_EN_BIT];

	// Target ramp: full scale takes rampTime tenths of a second
	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			tgtRamp_r <= '0;
			rampCnt_r <= '0;
		end
		else if (tick)
		begin
			if (rampBypass || cfg.rampTime == 8'h00)
			begin
				tgtRamp_r <= signed'({16'h0000, target});
				rampCnt_r <= '0;
			end
			else if (rampCnt_r + 8'h01 >= cfg.rampTime)
			begin
				rampCnt_r <= '0;
				if (signed'({16'h0000, target}) > tgtRamp_r + RAMP_STEP)
					tgtRamp_r <= tgtRamp_r + RAMP_STEP;
				else if (signed'({16'h0000, target}) < tgtRamp_r - RAMP_STEP)
					tgtRamp_r <= tgtRamp_r - RAMP_STEP;
				else
					tgtRamp_r <= signed'({16'h0000, target});
			end
			else
				rampCnt_r <= rampCnt_r + 8'h01;
		end
	end

	always_comb
	begin
		fbScaled = (signed'({16'h0000, fbIn}) * signed'({22'h000000, cfg.fbGain})) / 100;
		err = tgtRamp_r - fbScaled;
		if (cfg.mode[MODE_POL_BIT])
			err = -err;
		pTerm = (err * signed'({22'h000000, cfg.kp})) / 100;
		dTerm = ((err - errPrev_r) * signed'({22'h000000, cfg.kd})) / 100;
		iLim = signed'({22'h000000, cfg.integClamp}) * 10;
		integ_nxt = integ_r + (err * signed'({22'h000000, cfg.ki})) / 1000;
		if (integ_nxt > iLim)
			integ_nxt = iLim;
		else if (integ_nxt < -iLim)
			integ_nxt = -iLim;
		oLim = signed'({18'h00000, cfg.outClamp});
		sum = pTerm + integ_nxt + dTerm;
		if (sum > oLim)
			sumClp_nxt = oLim;
		else if (sum < -oLim)
			sumClp_nxt = -oLim;
		else
			sumClp_nxt = sum;
	end

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			integ_r <= '0;
			errPrev_r <= '0;
			sumClp_r <= '0;
		end
		else if (tick && !loopEn)
		begin
			integ_r <= '0;
			errPrev_r <= '0;
			sumClp_r <= '0;
		end
		else if (tick)
		begin
			integ_r <= integ_nxt;
			errPrev_r <= err;
			sumClp_r <= sumClp_nxt;
		end
	end

	ppr_lowpass u_lowpass (
		.ref_clk(ref_clk),
		.rstSyncB(rstSyncB),
		.tick(tick),
		.x(sumClp_r),
		.lpTime(cfg.lpTime),
		.y(lpOut)
	);

	// Percent of max frequency, bias in whole percent, output gain in tenths
	always_comb
	begin
		comp = ((lpOut + 32'(cfg.bias) * 100) * signed'({24'h000000, cfg.outGain})) / 10;
		// Product held at 64 bits: full gain times max frequency overflows 32
		freqCmd = signed'({16'h0000, freqRef})
			+ 32'((64'(comp) * signed'({48'h000000000000, maxFreq})) / PCT_FULL);
		cmdNeg = freqCmd < 0;
		if (cmdNeg && cfg.reverseAllow)
			cmdMag = 16'(-freqCmd);
		else if (cmdNeg)
			cmdMag = 16'h0000;
		else
			cmdMag = 16'(freqCmd);
	end

	assign sleepF = (cfg.sleepFreq > FREQ_MAX) ? FREQ_MAX : cfg.sleepFreq;
	assign wakeF = (cfg.wakeFreq > FREQ_MAX) ? FREQ_MAX : cfg.wakeFreq;
	assign sleepLim = TMR_W'(((cfg.sleepDelay > DELAY_MAX) ? DELAY_MAX : cfg.sleepDelay)
		* TICKS_PER_TENTH);
	assign wakeLim = TMR_W'(((cfg.wakeDelay > DELAY_MAX) ? DELAY_MAX : cfg.wakeDelay)
		* TICKS_PER_TENTH);
	assign lossLim = TMR_W'(((cfg.lossTime > LOSS_TIME_MAX) ? LOSS_TIME_MAX : cfg.lossTime)
		* TICKS_PER_TENTH);

	assign lossCond = loopEn && cfg.lossSel != LOSS_OFF
		&& 32'(fbIn) < 32'((cfg.lossLevel > LOSS_LEVEL_MAX) ? LOSS_LEVEL_MAX : cfg.lossLevel)
		* 100;
	assign sleepCond = loopEn && cfg.sleepSel == SLEEP_LEVEL && state_r == ST_RUN
		&& (cfg.sleepComp ? cmdMag < sleepF : outFreq_r < sleepF);
	assign wakeCond = loopEn && cfg.sleepSel == SLEEP_LEVEL && state_r == ST_SLEEP
		&& cmdMag > wakeF;

	ppr_hold_timer #(.CNT_W(TMR_W)) u_loss_tmr (
		.ref_clk(ref_clk),
		.rstSyncB(rstSyncB),
		.tick(tick),
		.cond(lossCond),
		.limit(lossLim),
		.done(lossDone)
	);

	ppr_hold_timer #(.CNT_W(TMR_W)) u_sleep_tmr (
		.ref_clk(ref_clk),
		.rstSyncB(rstSyncB),
		.tick(tick),
		.cond(sleepCond),
		.limit(sleepLim),
		.done(sleepDone)
	);

	ppr_hold_timer #(.CNT_W(TMR_W)) u_wake_tmr (
		.ref_clk(ref_clk),
		.rstSyncB(rstSyncB),
		.tick(tick),
		.cond(wakeCond),
		.limit(wakeLim),
		.done(wakeDone)
	);

	assign lossFaultHit = lossDone && cfg.lossSel == LOSS_FAULT;
	assign sleepEnter = (cfg.sleepSel == SLEEP_LEVEL && sleepDone)
		|| (cfg.sleepSel == SLEEP_INPUT && sleepInput);
	assign wakeExit = cfg.sleepSel == SLEEP_OFF || wakeDone
		|| (cfg.sleepSel == SLEEP_INPUT && !sleepInput);

	// Fault holds until the loop is switched off, so a flickering sensor cannot restart it
	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			state_r <= ST_RUN;
		else if (!loopEn)
			state_r <= ST_RUN;
		else
		begin
			unique case (state_r)
				ST_RUN:
					if (lossFaultHit)
						state_r <= ST_FAULT;
					else if (sleepEnter)
						state_r <= ST_SLEEP;
				ST_SLEEP:
					if (lossFaultHit)
						state_r <= ST_FAULT;
					else if (wakeExit)
						state_r <= ST_RUN;
				ST_FAULT:
					state_r <= ST_FAULT;
				default:
					state_r <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			outFreq_r <= '0;
			dirRev_r <= 1'b0;
		end
		else if (tick)
		begin
			if (!loopEn)
			begin
				outFreq_r <= freqRef;
				dirRev_r <= 1'b0;
			end
			else if (state_r == ST_FAULT)
			begin
				outFreq_r <= '0;
				dirRev_r <= 1'b0;
			end
			else if (state_r == ST_SLEEP)
			begin
				outFreq_r <= cfg.sleepComp ? sleepF : 16'h0000;
				dirRev_r <= 1'b0;
			end
			else
			begin
				if (cfg.sleepComp && sleepCond && cmdMag < minFreq)
					outFreq_r <= minFreq;
				else
					outFreq_r <= cmdMag;
				dirRev_r <= cmdNeg && cfg.reverseAllow;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			conflict_r <= 1'b0;
		else
			conflict_r <= (cfg.sleepSel == SLEEP_LEVEL || cfg.sleepSel == SLEEP_INPUT)
				&& cfg.reverseAllow;
	end

	assign outFreq = outFreq_r;
	assign dirRev = dirRev_r;
	assign driveRun = !loopEn || state_r == ST_RUN
		|| (state_r == ST_SLEEP && cfg.sleepComp);
	assign sleeping = state_r == ST_SLEEP;
	assign lossMsg = loopEn && cfg.lossSel != LOSS_OFF
		&& (lossDone || state_r == ST_FAULT);
	assign faultRelay = state_r == ST_FAULT;
	assign conflictAlarm = conflict_r;
	assign pidOut = lpOut;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSyncB);

	sequence lossFaultSeen;
		loopEn && lossFaultHit && state_r != ST_FAULT;
	endsequence

	sequence sleepDue;
		loopEn && state_r == ST_RUN && cfg.sleepSel == SLEEP_LEVEL && sleepDone && !lossFaultHit;
	endsequence

	chk_loop_off_pass: assert property (tick && !loopEn |=> outFreq_r == $past(freqRef))
		else $error("disabled loop did not pass the reference");
	chk_integ_clamp: assert property (tick && loopEn |=> integ_r <= $past(iLim)
		&& integ_r >= -$past(iLim)) else $error("integral beyond its clamp");
	chk_sum_clamp: assert property (tick && loopEn |=> sumClp_r <= $past(oLim)
		&& sumClp_r >= -$past(oLim)) else $error("output beyond its clamp");
	chk_no_reverse: assert property (tick && loopEn && !cfg.reverseAllow |=> !dirRev_r)
		else $error("reversed without permission");
	chk_loss_fault: assert property (lossFaultSeen |=> faultRelay && !driveRun && lossMsg)
		else $error("feedback loss fault not taken");
	chk_loss_warn: assert property (loopEn && lossDone && cfg.lossSel == LOSS_WARN
		&& state_r == ST_RUN |=> lossMsg && state_r != ST_FAULT || !loopEn || !lossDone)
		else $error("loss warning wrong");
	chk_sleep_entry: assert property (sleepDue |=> state_r == ST_SLEEP ##0 !driveRun
		|| cfg.sleepComp) else $error("sleep not entered on expiry");
	chk_wake_exit: assert property (loopEn && state_r == ST_SLEEP && wakeDone
		&& !lossFaultHit |=> state_r == ST_RUN) else $error("wake not taken");
	chk_conflict_alarm: assert property (cfg.sleepSel != SLEEP_OFF && cfg.reverseAllow
		&& cfg.sleepSel != 2'h3 ##1 $stable(cfg) |-> conflictAlarm)
		else $error("conflict alarm missing");
endmodule

// ### dv/ppr_transducer.sv
/*
 Far-side model: process transducer and speed reference path feeding the regulator.
 Assumes the bench sets the wanted levels; outputs move one clock later, like a sampled sensor.
*/
`timescale 1ns/1ps
module ppr_transducer
	import ppr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [15:0] fbSet,
	input wire logic [15:0] refSet,
	input wire logic bypassReq,
	output logic [15:0] fbIn,
	output logic [15:0] freqRef,
	output logic rampBypass
);
	// One clock of transport delay so the sensor is never faster than the bench
	always_ff @(posedge ref_clk)
	begin
		fbIn <= fbSet;
		freqRef <= refSet;
		rampBypass <= bypassReq;
	end
endmodule

// ### dv/test_ppr_regulator.sv
/*
 Self-checking bench of the process regulator: loop enable, polarity, gains, reversal,
 feedback loss, target ramp, output stage, sleep, wake-up and conflict alarm.
 Assumes TICK_COUNT shortened to 10.
*/
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module test_ppr_regulator
	import ppr_pkg::*;
;
	localparam int TC = 10;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	ppr_cfg_t cfg = '0;
	logic [15:0] target = 16'h0000;
	logic [15:0] fbSet = 16'h0000;
	logic [15:0] refSet = 16'h0BB8;
	logic bypassReq = 1'b0;
	logic [15:0] maxFreq = 16'h1770;
	logic [15:0] minFreq = 16'h0000;
	logic sleepInput = 1'b0;
	logic [15:0] fbIn;
	logic [15:0] freqRef;
	logic rampBypass;
	logic [15:0] outFreq;
	logic dirRev;
	logic driveRun;
	logic sleeping;
	logic lossMsg;
	logic faultRelay;
	logic conflictAlarm;
	logic signed [31:0] pidOut;
	int n_errors = 0;
	int tests_run = 0;

	ppr_transducer partner (.ref_clk(ref_clk), .fbSet(fbSet), .refSet(refSet),
		.bypassReq(bypassReq), .fbIn(fbIn), .freqRef(freqRef), .rampBypass(rampBypass));

	ppr_regulator #(.TICK_COUNT(TC)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
		.target(target), .fbIn(fbIn), .freqRef(freqRef), .maxFreq(maxFreq),
		.minFreq(minFreq), .rampBypass(rampBypass), .sleepInput(sleepInput),
		.outFreq(outFreq), .dirRev(dirRev), .driveRun(driveRun), .sleeping(sleeping),
		.lossMsg(lossMsg), .faultRelay(faultRelay), .conflictAlarm(conflictAlarm),
		.pidOut(pidOut));

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n * TC) @(posedge ref_clk);
		#1;
	endtask

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Loop off passes the frequency reference straight through
	task automatic t_disabled();
		@(posedge ref_clk);
		cfg.mode <= 4'h0;
		ticks(3);
		`CHK(outFreq, 16'h0BB8);
		`CHK(dirRev, 1'b0);
		`CHK(driveRun, 1'b1);
	endtask

	// Sign of the error decides the direction once reversal is allowed
	task automatic t_polarity();
		@(posedge ref_clk);
		cfg.mode <= 4'h1;
		cfg.kp <= 10'h064;
		cfg.fbGain <= 10'h064;
		cfg.outClamp <= 14'h2710;
		cfg.outGain <= 8'h0A;
		target <= 16'h1388;
		fbSet <= 16'h0BB8;
		ticks(15);
		`CHK(dirRev, 1'b0);
		`CHK(pidOut, 32'h000007D0);
		@(posedge ref_clk);
		cfg.reverseAllow <= 1'b1;
		cfg.fbGain <= 10'h3E8;
		ticks(15);
		`CHK(dirRev, 1'b1);
		`CHK(pidOut, 32'hFFFFD8F0);
		`CHK(outFreq, 16'h0BB8);
		@(posedge ref_clk);
		cfg.mode <= 4'h3;
		ticks(15);
		`CHK(dirRev, 1'b0);
		`CHK(pidOut, 32'h00002710);
		@(posedge ref_clk);
		cfg.mode <= 4'h1;
		cfg.reverseAllow <= 1'b0;
		ticks(15);
		`CHK(dirRev, 1'b0);
		`CHK(outFreq, 16'h0000);
	endtask

	// Target ramp and its bypass, bias with output gain, then the output low-pass
	task automatic t_ramp_out();
		@(posedge ref_clk);
		bypassReq <= 1'b0;
		cfg.fbGain <= 10'h000;
		cfg.rampTime <= 8'h0A;
		repeat (2) @(posedge ref_clk);
		target <= 16'h1770;
		ticks(20);
		`CHK(pidOut < 32'sh00001770, 1'b1);
		ticks(100);
		`CHK(pidOut, 32'h00001770);
		@(posedge ref_clk);
		bypassReq <= 1'b1;
		target <= 16'h1F40;
		ticks(6);
		`CHK(pidOut, 32'h00001F40);
		`CHK(outFreq, 16'h1E78);
		@(posedge ref_clk);
		cfg.bias <= 8'h0A;
		cfg.outGain <= 8'h14;
		ticks(3);
		`CHK(outFreq, 16'h35E8);
		@(posedge ref_clk);
		cfg.lpTime <= 10'h001;
		target <= 16'h0000;
		ticks(4);
		`CHK(pidOut > 32'sh00000000, 1'b1);
	endtask

	// Threshold sleep, clamped sleep frequency with compensation, then wake-up
	task automatic t_sleep_level();
		@(posedge ref_clk);
		cfg.bias <= 8'h00;
		cfg.outGain <= 8'h0A;
		cfg.lpTime <= 10'h000;
		cfg.reverseAllow <= 1'b0;
		target <= 16'h0000;
		cfg.sleepSel <= SLEEP_LEVEL;
		cfg.sleepFreq <= 16'h1770;
		cfg.wakeFreq <= 16'hFFFF;
		ticks(8);
		`CHK(sleeping, 1'b1);
		`CHK(driveRun, 1'b0);
		`CHK(outFreq, 16'h0000);
		`CHK(conflictAlarm, 1'b0);
		@(posedge ref_clk);
		cfg.sleepComp <= 1'b1;
		cfg.sleepFreq <= 16'hFFFF;
		ticks(3);
		`CHK(outFreq, FREQ_MAX);
		`CHK(driveRun, 1'b1);
		@(posedge ref_clk);
		cfg.sleepComp <= 1'b0;
		cfg.sleepFreq <= 16'h0000;
		cfg.wakeFreq <= 16'h03E8;
		ticks(3);
		`CHK(sleeping, 1'b0);
		`CHK(outFreq, 16'h0BB8);
	endtask

	// Loss warning: timer clears on a short recovery, then declares after the full time
	task automatic t_loss_warn();
		@(posedge ref_clk);
		cfg.lossSel <= LOSS_WARN;
		cfg.lossLevel <= 7'h32;
		cfg.lossTime <= 7'h01;
		fbSet <= 16'h0000;
		ticks(60);
		@(posedge ref_clk);
		fbSet <= 16'h1388;
		ticks(5);
		@(posedge ref_clk);
		fbSet <= 16'h0000;
		ticks(60);
		`CHK(lossMsg, 1'b0);
		ticks(35);
		`CHK(lossMsg, 1'b0);
		ticks(10);
		`CHK(lossMsg, 1'b1);
		`CHK(driveRun, 1'b1);
		`CHK(faultRelay, 1'b0);
	endtask

	// Fault response stops the drive and latches until the loop is switched off
	task automatic t_loss_fault();
		@(posedge ref_clk);
		cfg.lossSel <= LOSS_OFF;
		ticks(120);
		`CHK(lossMsg, 1'b0);
		@(posedge ref_clk);
		cfg.lossSel <= LOSS_FAULT;
		ticks(105);
		`CHK(faultRelay, 1'b1);
		`CHK(driveRun, 1'b0);
		`CHK(lossMsg, 1'b1);
		`CHK(outFreq, 16'h0000);
		@(posedge ref_clk);
		cfg.lossSel <= LOSS_OFF;
		cfg.mode <= 4'h0;
		fbSet <= 16'h1388;
		ticks(2);
		`CHK(faultRelay, 1'b0);
		`CHK(driveRun, 1'b1);
	endtask

	// Sleep from the multi-input, and the conflict with reversal permission
	task automatic t_sleep_input();
		@(posedge ref_clk);
		cfg.sleepSel <= SLEEP_INPUT;
		cfg.mode <= 4'h1;
		sleepInput <= 1'b1;
		ticks(3);
		`CHK(sleeping, 1'b1);
		`CHK(driveRun, 1'b0);
		@(posedge ref_clk);
		sleepInput <= 1'b0;
		ticks(3);
		`CHK(sleeping, 1'b0);
		@(posedge ref_clk);
		cfg.reverseAllow <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(conflictAlarm, 1'b1);
		@(posedge ref_clk);
		cfg.sleepSel <= SLEEP_OFF;
		sleepInput <= 1'b1;
		bypassReq <= 1'b1;
		ticks(3);
		`CHK(conflictAlarm, 1'b0);
		`CHK(sleeping, 1'b0);
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_disabled();
		t_polarity();
		t_loss_warn();
		t_loss_fault();
		t_sleep_input();
		t_ramp_out();
		t_sleep_level();
		end_of_test();
	end

	// Whole sequence needs roughly 6200 cycles; allow a wide margin
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		n_errors++;
		end_of_test();
	end
endmodule
